// File: src/psu_fault_supervisor.v
// How it works
// - malfunctions split into warnings and errors
// - an error opens the supply contact unless mains is already absent
// - limits are checked in operating and warning states
// - any quantity beyond its limit enters the error state
// - errors latch until the next reset
// - undervoltage latches only when drawing mains, else self-clears
// - clear input rising edge with preconditions goes to await mains
// - after control power cycle, start in await mains if allowed
// - reset refused until the error's hold interval has elapsed
// - energy errors also refused until the energy is discharged
// - hold interval is discarded on control power loss
// - brake, charge and cable energy survive power loss; device not
// - brake and charge energy: 1 % per 0.5 s, all in 50 s
// - cable energy per channel: 1 % per 24.8 s, all in 2480 s
// - device energy 1 % per 0.15 s; per channel 1 % per 0.17 s
// - rms undervoltage gives code 1, hold 5 s
// - rms overvoltage gives code 2, hold 5 s
// - ripple over 25 % for 700 ms gives code 3, hold 10 s
// - clear requests over the bus link are ignored
// - after the hold time, recover or stay in error
`include "psu_fault_consts.vh"
module psu_fault_supervisor #(
   parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
   input wire clk,
   input wire reset_n,
   input wire fault_clear_input,
   input wire bus_clear_request,
   input wire mains_input_voltage,
   input wire mains_ok,
   input wire check_done,
   input wire check_pass,
   input wire under_voltage,
   input wire over_voltage,
   input wire ripple_high,
   input wire warning_level,
   input wire [6:0] energy_overload,
   input wire [27:0] nv_energy_in,
   input wire nv_valid,
   output reg supply_enable_contact,
   output reg [5:0] state_ff,
   output reg [3:0] error_code_ff,
   output reg error_active_ff,
   output reg warning_active_ff,
   output reg [27:0] nv_energy_out,
   output wire reset_allowed
);
   localparam [31:0] RIPPLE_TICKS = `RIPPLE_MS / `TICK_MS;

   // 1 % step lengths in ticks per accumulator
   function [31:0] step_ticks;
      input integer idx;
      begin
         case (idx)
            0: step_ticks = `DECAY_BRAKE_MS / `TICK_MS;
            1: step_ticks = `DECAY_CHARGE_MS / `TICK_MS;
            2: step_ticks = `DECAY_CABLE_MS / `TICK_MS;
            3: step_ticks = `DECAY_CABLE_MS / `TICK_MS;
            4: step_ticks = `DECAY_DEV_MS / `TICK_MS;
            default: step_ticks = `DECAY_DEVCH_MS / `TICK_MS;
         endcase
      end
   endfunction

   // hold interval in ticks for an error code
   function [31:0] hold_ticks;
      input [3:0] code;
      begin
         case (code)
            `CODE_UNDERVOLT: hold_ticks = `HOLD_UNDERVOLT_S * `TICKS_PER_S;
            `CODE_OVERVOLT: hold_ticks = `HOLD_OVERVOLT_S * `TICKS_PER_S;
            `CODE_RIPPLE: hold_ticks = `HOLD_RIPPLE_S * `TICKS_PER_S;
            default: hold_ticks = `HOLD_ENERGY_S * `TICKS_PER_S;
         endcase
      end
   endfunction

   // three-stage synchroniser for the clear pin
   reg [2:0] clr_sync_ff;
   reg clr_state_ff;
   reg clr_prev_ff;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clr_sync_ff <= 3'h0;
         clr_state_ff <= 1'b0;
      end else begin
         clr_sync_ff <= {clr_sync_ff[1:0], fault_clear_input};
         // a level counts once the second and third stage agree
         if (clr_sync_ff[1] == clr_sync_ff[2])
            clr_state_ff <= clr_sync_ff[2];
      end
   end

   // previous settled level, reset high so reset makes no false edge
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) clr_prev_ff <= 1'b1;
      else clr_prev_ff <= clr_state_ff;
   end

   // low sample then high sample
   wire clr_rise = clr_state_ff & ~clr_prev_ff;

   // three-stage synchroniser for the mains presence pin
   reg [2:0] mains_sync_ff;
   reg mains_state_ff;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mains_sync_ff <= 3'h0;
         mains_state_ff <= 1'b0;
      end else begin
         mains_sync_ff <= {mains_sync_ff[1:0], mains_input_voltage};
         if (mains_sync_ff[1] == mains_sync_ff[2])
            mains_state_ff <= mains_sync_ff[2];
      end
   end

   // shared time base
   // one pulse every TICK_CYCLES clocks drives all slow timing
   reg [31:0] tick_cnt_ff;
   reg tick_ff;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_ff <= 32'd0;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff >= TICK_CYCLES - 32'd1) begin
         tick_cnt_ff <= 32'd0;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'd1;
         tick_ff <= 1'b0;
      end
   end

   // energy accumulators, one per overload source
   wire [6:0] drained;
   wire [48:0] levels;
   genvar gi;
   generate
      for (gi = 0; gi < `N_ENERGY; gi = gi + 1) begin : g_energy
         wire [6:0] nv_in;
         if (gi < 4) begin : g_nv
            assign nv_in = nv_energy_in[gi*7 +: 7];
         end else begin : g_vol
            assign nv_in = 7'h00;
         end
         energy_decay #(
            .STEP_TICKS(step_ticks(gi)),
            .NV((`ENERGY_NV_MASK >> gi) & 1)
         ) u_decay (
            .clk(clk),
            .reset_n(reset_n),
            .tick(tick_ff),
            .overload(energy_overload[gi]),
            .nv_level(nv_in),
            .nv_valid(nv_valid),
            .level_ff(levels[gi*7 +: 7]),
            .drained(drained[gi])
         );
      end
   endgenerate

   // save only the retained accumulators
   // the device accumulators 4 to 6 are volatile and never saved
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nv_energy_out <= 28'h0000000;
      end else begin
         nv_energy_out <= levels[27:0];
      end
   end

   // ripple persistence counter, restarts whenever ripple drops
   reg [31:0] ripple_cnt_ff;
   wire ripple_err = (ripple_cnt_ff >= RIPPLE_TICKS);
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ripple_cnt_ff <= 32'd0;
      end else if (!ripple_high) begin
         ripple_cnt_ff <= 32'd0;
      end else if (tick_ff && !ripple_err) begin
         // stops at the limit so the count cannot wrap
         ripple_cnt_ff <= ripple_cnt_ff + 32'd1;
      end
   end

   // monitoring applies only in operating and warning states
   wire monitoring = (state_ff == `ST_OPER) || (state_ff == `ST_WARN);
   wire energy_trip = |energy_overload;
   wire any_trip = under_voltage | over_voltage | ripple_err | energy_trip;

   // priority code of the detected error
   reg [3:0] trip_code;
   always @* begin
      if (under_voltage) trip_code = `CODE_UNDERVOLT;
      else if (over_voltage) trip_code = `CODE_OVERVOLT;
      else if (ripple_err) trip_code = `CODE_RIPPLE;
      else trip_code = `CODE_ENERGY;
   end

   // hold interval counter, volatile so lost on power-down
   reg [31:0] hold_cnt_ff;
   reg under_on_mains_ff;
   wire hold_done = (hold_cnt_ff == 32'd0);
   assign reset_allowed = error_active_ff && hold_done
      && (&drained);

   // self-clearing undervoltage when not drawing from mains
   wire auto_clear = error_active_ff && !under_on_mains_ff
      && (error_code_ff == `CODE_UNDERVOLT) && mains_state_ff
      && !under_voltage;

   // a clear is taken only from the pin, never from the bus
   wire clear_taken = clr_rise && reset_allowed;

   reg [5:0] nxt_state;
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `ST_OFF: begin
            // wait for a saved level to load before judging the drain
            if (&drained && !nv_valid) nxt_state = `ST_AWAIT;
         end
         `ST_AWAIT: if (mains_ok) nxt_state = `ST_CHECK;
         `ST_CHECK: begin
            if (check_done)
               nxt_state = check_pass ? `ST_OPER : `ST_FAULT;
         end
         `ST_OPER, `ST_WARN: begin
            if (monitoring && any_trip)
               nxt_state = `ST_FAULT;
            else if (warning_level)
               nxt_state = `ST_WARN;
            else
               nxt_state = `ST_OPER;
         end
         `ST_FAULT: begin
            // bus_clear_request has no effect here
            if (clear_taken || auto_clear)
               nxt_state = `ST_AWAIT;
         end
         default: nxt_state = `ST_OFF;
      endcase
   end

   // fault entry and exit events
   wire fault_entry = (state_ff != `ST_FAULT) && (nxt_state == `ST_FAULT);
   wire fault_exit = (state_ff == `ST_FAULT) && (nxt_state == `ST_AWAIT);
   // code of the error being entered; a failed output check reports 1
   wire [3:0] entry_code = any_trip ? trip_code : `CODE_UNDERVOLT;

   // operating state register; reset discards the running hold
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) state_ff <= `ST_OFF;
      else state_ff <= nxt_state;
   end

   // warning class flag, shown while the state is warning
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) warning_active_ff <= 1'b0;
      else warning_active_ff <= (nxt_state == `ST_WARN);
   end

   // latched error and its code, held until a reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         error_active_ff <= 1'b0;
         error_code_ff <= `CODE_NONE;
      end else if (fault_entry) begin
         error_active_ff <= 1'b1;
         error_code_ff <= entry_code;
      end else if (fault_exit) begin
         error_active_ff <= 1'b0;
         error_code_ff <= `CODE_NONE;
      end
   end

   // hold interval, volatile so lost on power-down
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) hold_cnt_ff <= 32'd0;
      else if (fault_entry) hold_cnt_ff <= hold_ticks(entry_code);
      else if (tick_ff && !hold_done)
         hold_cnt_ff <= hold_cnt_ff - 32'd1;
   end

   // remember whether the fault arose while drawing from mains
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) under_on_mains_ff <= 1'b0;
      else if (fault_entry) under_on_mains_ff <= mains_state_ff;
   end

   // contact closed outside power-off; in fault it opens unless mains
   // is already gone, which leaves nothing to interrupt
   wire contact_open = (nxt_state == `ST_FAULT) && mains_state_ff;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) supply_enable_contact <= 1'b0;
      else supply_enable_contact <= (nxt_state != `ST_OFF) && !contact_open;
   end
endmodule

// File: src/psu_fault_consts.vh
`ifndef PSU_FAULT_CONSTS_VH
`define PSU_FAULT_CONSTS_VH
// system clock rate
`define CLK_HZ 200000000
// sub-tick for hold timing and energy decay (10 ms)
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
// error codes
`define CODE_NONE 4'h0
`define CODE_UNDERVOLT 4'h1
`define CODE_OVERVOLT 4'h2
`define CODE_RIPPLE 4'h3
`define CODE_ENERGY 4'h7
// hold intervals in seconds, scaled by TICKS_PER_S ticks of 10 ms
`define HOLD_UNDERVOLT_S 5
`define HOLD_OVERVOLT_S 5
`define HOLD_RIPPLE_S 10
`define HOLD_ENERGY_S 10
`define TICKS_PER_S 100
// ripple persistence in ms
`define RIPPLE_MS 700
// decay: 1 % time in ms per energy class (100 % is 100 times that)
`define DECAY_BRAKE_MS 500
`define DECAY_CHARGE_MS 500
`define DECAY_CABLE_MS 24800
`define DECAY_DEV_MS 150
`define DECAY_DEVCH_MS 170
// energy accumulators: number and full scale (percent)
`define N_ENERGY 7
`define ENERGY_FULL 7'h64
// non-volatile mask: brake, charge, cable ch1, cable ch2
`define ENERGY_NV_MASK 7'h0F
// one-hot states
`define ST_AWAIT 6'h01
`define ST_CHECK 6'h02
`define ST_OPER 6'h04
`define ST_WARN 6'h08
`define ST_FAULT 6'h10
`define ST_OFF 6'h20
`endif

// File: src/energy_decay.v
`include "psu_fault_consts.vh"
// one accumulated-energy channel: loads on overload, loses 1 % per step
module energy_decay #(
   parameter [31:0] STEP_TICKS = 32'd50,
   parameter NV = 0
) (
   input wire clk,
   input wire reset_n,
   input wire tick,
   input wire overload,
   input wire [6:0] nv_level,
   input wire nv_valid,
   output reg [6:0] level_ff,
   output wire drained
);
   reg [31:0] step_ff;
   reg [31:0] nxt_step;
   reg [6:0] nxt_level;
   reg nv_taken_ff;

   // decay one percent per step, restore a saved level once if kept
   always @* begin
      nxt_level = level_ff;
      nxt_step = step_ff;
      if (nv_valid && !nv_taken_ff && NV != 0) begin
         nxt_level = nv_level;
      end else if (overload) begin
         nxt_level = `ENERGY_FULL;
         nxt_step = 32'd0;
      end else if (tick && level_ff != 7'h00) begin
         if (step_ff >= STEP_TICKS - 32'd1) begin
            nxt_step = 32'd0;
            nxt_level = level_ff - 7'h01;
         end else begin
            nxt_step = step_ff + 32'd1;
         end
      end
   end

   // state registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_ff <= 7'h00;
         step_ff <= 32'd0;
         nv_taken_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
         step_ff <= nxt_step;
         if (nv_valid) nv_taken_ff <= 1'b1;
      end
   end

   assign drained = (level_ff == 7'h00);
endmodule

// File: verification/psu_fault_monitor.sv
module psu_fault_monitor #(
   parameter [31:0] TICK_CYCLES = 32'd10
) (
   input wire clk,
   input wire reset_n,
   input wire fault_clear_input,
   input wire mains_input_voltage,
   input wire under_voltage,
   input wire over_voltage,
   input wire ripple_high,
   input wire warning_level,
   input wire [6:0] energy_overload,
   input wire supply_enable_contact,
   input wire [5:0] state_ff,
   input wire [3:0] error_code_ff,
   input wire error_active_ff,
   input wire warning_active_ff,
   input wire reset_allowed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // no other monitor is asking for attention
   wire quiet = !ripple_high && energy_overload == 7'h00;
   // a legal clear edge while the fault may be cleared
   sequence seq_clear_rise;
      (state_ff == 6'h10 && reset_allowed && !fault_clear_input)
      ##1 (fault_clear_input && reset_allowed) [*3];
   endsequence
   // a settled fault with mains present and no clear pending
   sequence seq_idle_fault;
      (mains_input_voltage && !fault_clear_input) [*6] ##0 state_ff == 6'h10;
   endsequence
   AST_CLEAR_TO_AWAIT: assert property (
      seq_clear_rise |-> ##[1:4] state_ff == 6'h01)
      else $error("clear edge did not reach await");
   AST_FAULT_LATCH: assert property (
      seq_idle_fault |=> state_ff == 6'h10)
      else $error("fault left without clear edge");
   AST_REFUSE: assert property (
      (state_ff == 6'h10 && !reset_allowed && mains_input_voltage)
      |=> state_ff == 6'h10) else $error("fault left while refused");
   AST_OPEN_CONTACT: assert property (
      (mains_input_voltage [*6] ##0 state_ff == 6'h10)
      |-> !supply_enable_contact) else $error("contact closed in fault");
   AST_UNDER_CODE: assert property (
      (state_ff == 6'h04 && under_voltage && !over_voltage && quiet)
      |-> ##[1:4] (state_ff == 6'h10 && error_code_ff == 4'h1))
      else $error("undervoltage not reported");
   AST_OVER_CODE: assert property (
      (state_ff == 6'h04 && over_voltage && !under_voltage && quiet)
      |-> ##[1:4] (state_ff == 6'h10 && error_code_ff == 4'h2))
      else $error("overvoltage not reported");
   AST_ERR_FLAG: assert property (
      state_ff == 6'h10 |-> error_active_ff)
      else $error("fault state without error flag");
   AST_WARN_CLASS: assert property (
      state_ff == 6'h04 ##1 (warning_level && !under_voltage &&
      !over_voltage && quiet) [*4] |-> state_ff == 6'h08 &&
      warning_active_ff && !error_active_ff)
      else $error("warning not classed");
endmodule

bind psu_fault_supervisor psu_fault_monitor #(
   .TICK_CYCLES(TICK_CYCLES)
) u_mon (.*);

// File: verification/clear_ctrl_model.sv
module clear_ctrl_model (
   input wire logic clk,
   input wire logic reset_allowed,
   input wire logic go,
   input wire logic eager,
   output logic clear_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pend = 1'b0;
   initial clear_pin = 1'b0;
   // waits for permission unless told to be eager, then pulses the pin
   always begin
      @(posedge clk);
      #2;
      if (go) pend = 1'b1;
      if (pend && (reset_allowed || eager)) begin
         pend = 1'b0;
         clear_pin = 1'b1;
         repeat (4) @(posedge clk);
         #2 clear_pin = 1'b0;
      end
   end
endmodule

// File: verification/tb_psu_fault_supervisor.sv
module tb_psu_fault_supervisor;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset_n = 0, bus_clr = 0, mains = 1, m_ok = 1, go = 0;
   logic under = 0, over = 0, ripple = 0, warn = 0, nv_valid = 0, eager = 0;
   logic [6:0] ovl = 7'h00;
   logic [27:0] nv_in = 28'h0000000;
   wire clr_pin, contact, allowed, err_act, warn_act;
   wire [5:0] st;
   wire [3:0] code;
   wire [27:0] nv_out;
   int err_total = 0, n_checks = 0, cycles = 0;
   always #2.5 clk = ~clk;
   psu_fault_supervisor #(.TICK_CYCLES(32'd10)) i_dut (.clk(clk),
      .reset_n(reset_n), .fault_clear_input(clr_pin),
      .bus_clear_request(bus_clr), .mains_input_voltage(mains),
      .mains_ok(m_ok), .check_done(1'b1), .check_pass(1'b1),
      .under_voltage(under), .over_voltage(over), .ripple_high(ripple),
      .warning_level(warn), .energy_overload(ovl), .nv_energy_in(nv_in),
      .nv_valid(nv_valid), .supply_enable_contact(contact),
      .state_ff(st), .error_code_ff(code), .error_active_ff(err_act),
      .warning_active_ff(warn_act), .nv_energy_out(nv_out),
      .reset_allowed(allowed));
   clear_ctrl_model i_ctrl (.clk(clk), .reset_allowed(allowed), .go(go),
      .eager(eager), .clear_pin(clr_pin));
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk_val(input logic [7:0] got, input logic [7:0] exp, string w);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp, string w);
      chk_val({7'h00, got}, {7'h00, exp}, w);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wait_st(input logic [5:0] s, input int lim);
      for (int i = 0; i < lim && st !== s; i++) cyc(1);
      chk_val({2'b00, st}, {2'b00, s}, "state");
   endtask
   // wait for the fault state and check its code
   task trip(input logic [3:0] c);
      wait_st(6'h10, 20);
      chk_val({4'h0, code}, {4'h0, c}, "code");
   endtask
   // clear is refused before the wait, accepted after it
   task hold_clear(input int hold);
      m_ok = 0;
      cyc(hold - 100);
      chk_bit(allowed, 0, "allowed early");
      cyc(200);
      chk_bit(allowed, 1, "allowed late");
      go = 1;
      cyc(1);
      go = 0;
      wait_st(6'h01, 20);
      chk_bit(err_act, 0, "error flag");
      m_ok = 1;
      wait_st(6'h04, 50);
   endtask
   task t_under;
      warn = 1;
      cyc(6);
      chk_bit(warn_act, 1, "warning");
      warn = 0;
      wait_st(6'h04, 20);
      under = 1;
      cyc(2);
      under = 0;
      trip(4'h1);
      chk_bit(contact, 0, "contact");
      {eager, go, bus_clr} = 3'b111;
      cyc(1);
      go = 0;
      cyc(20);
      {eager, bus_clr} = 2'b00;
      chk_val({2'b00, st}, 8'h10, "early clear");
      hold_clear(5000);
      $display("test under done");
   endtask
   task t_over;
      over = 1;
      cyc(2);
      over = 0;
      trip(4'h2);
      hold_clear(5000);
      $display("test over done");
   endtask
   task t_ripple;
      ripple = 1;
      cyc(650);
      chk_val({2'b00, st}, 8'h04, "ripple early");
      wait_st(6'h10, 100);
      ripple = 0;
      chk_val({4'h0, code}, 8'h03, "code");
      hold_clear(10000);
      $display("test ripple done");
   endtask
   task t_energy;
      ovl = 7'h10;
      cyc(2);
      ovl = 7'h00;
      trip(4'h7);
      hold_clear(15000);
      $display("test energy done");
   endtask
   task t_power;
      ovl = 7'h01;
      cyc(2);
      ovl = 7'h00;
      trip(4'h7);
      cyc(20);
      chk_val({1'b0, nv_out[6:0]}, 8'h64, "saved level");
      reset_n = 0;
      cyc(2);
      chk_val({2'b00, st}, 8'h20, "off");
      nv_in = 28'h0000002;
      {reset_n, nv_valid} = 2'b11;
      cyc(1);
      nv_valid = 0;
      cyc(900);
      chk_val({2'b00, st}, 8'h20, "drain");
      wait_st(6'h04, 300);
      chk_bit(err_act, 0, "error flag");
      $display("test power done");
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         $display("CHECK FAILED t=%0t timeout", $time);
         results;
      end
   end
   initial begin
      cyc(6);
      reset_n = 1;
      wait_st(6'h04, 100);
      t_under;
      t_over;
      t_ripple;
      t_energy;
      t_power;
      results;
   end
endmodule
